// *** sfr_regs.svh ***
`ifndef SFR_REGS_SVH
`define SFR_REGS_SVH

// APB byte offsets
`define SFR_OFS_CTRL    8'h00
`define SFR_OFS_OPC     8'h04
`define SFR_OFS_GAP     8'h08
`define SFR_OFS_HOLD    8'h0c
`define SFR_OFS_PAGE    8'h10
`define SFR_OFS_MAP     8'h14

// Reset values
`define SFR_RST_CTRL    8'h01
`define SFR_RST_OPC     8'h03
`define SFR_RST_GAP     8'h07
`define SFR_RST_HOLD    16'h0010
`define SFR_RST_PAGE    8'h00
`define SFR_RST_MAP     9'h015

// Field positions
`define SFR_B_MBE       0
`define SFR_B_DIV       2
`define SFR_B_PAD       4
`define SFR_B_DUAL      5
`define SFR_B_CSS       6
`define SFR_B_PKS       7
`define SFR_B_PAGED     8
`define SFR_CTRL_WMASK  8'hfd

// Timing in master clock cycles
`define SFR_LEAD_CYC    17'h00002
`define SFR_LEAD_SHORT  17'h00001
`define SFR_HOLD_EXTRA  17'h00002
`define SFR_GAP_EXTRA   17'h00001

// Serial phase lengths in serial clocks
`define SFR_HDR_CLKS    7'h20
`define SFR_PAD_CLKS    7'h08
`define SFR_WORD_CLKS   7'h20
`define SFR_DUAL_CLKS   7'h10
`define SFR_WORD_BITS   6'h20

// Flash window 40_0000h..7F_FFFFh is haddr[31:22] == 1
`define SFR_WIN_TAG     10'h001
`define SFR_HRESP_OK    2'b00
`define SFR_HRESP_SPLIT 2'b11

`endif

// *** sfr_pkg.sv ***
package sfr_pkg;
    typedef enum logic [2:0] {ST_IDLE, ST_GAP, ST_LEAD, ST_SHIFT, ST_HOLD} sfr_eng_type;
    typedef enum logic [1:0] {RS_IDLE, RS_SPL1, RS_SPL2} sfr_resp_type;
endpackage : sfr_pkg

// *** sfr_bridge.sv ***
`include "sfr_regs.svh"

// How it works
// - Shift bits out on falling serial clock, sample on rising edge.
// - Reads in 40_0000h..7F_FFFFh go to the flash read path.
// - Flash address is raw, or page register joined with low AHB lines.
// - Setting bridge enable grabs the pin multiplexer at once.
// - Pins return only after bridge enable cleared and active flag reads zero.
// - Read-only active flag is one while this block owns the pins.
// - Divider select: 00 is /4, 01 is /2, 10 undivided inverted.
// - Pad bit inserts one dummy byte after the address.
// - Plain, fast and dual fast reads; flash up to 4 MB.
// - First attempt is split; master, address and size are latched.
// - Buffered first word re-grants the owner, which gets one word.
// - Next word is fetched while the owner is split again.
// - One owner; others split and remembered, re-granted after last word.
// - Held select plus sequential address skips opcode and address.
// - Non-sequential read with held select releases it for the gap.
// - Lead shorten bit cuts select-to-clock delay from 2 to 1.
// - Launch shorten bit starts next fetch divisor minus one earlier.
// - Hold register zero releases select right after the data.
// - Command phase sends the opcode register value.
// - Dual mode: even bits from io0, odd bits from io1.
// - Select stays high at least idle gap plus one cycles.
// - Nonzero hold keeps select low hold plus two cycles.
module sfr_bridge
    import sfr_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        nrst_i,
    // APB register port
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // AHB read slave
    input  wire logic        hsel_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [2:0]  hburst_i,
    input  wire logic [3:0]  hmaster_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hready_o,
    output logic      [1:0]  hresp_o,
    output logic      [15:0] hsplit_o,
    // Serial flash pins
    output logic             sck_o,
    output logic             cs_n_o,
    output logic             io0_o,
    output logic             io0_oe_o,
    input  wire logic        io0_i,
    input  wire logic        io1_i,
    // Pin multiplexer select
    output logic             pin_sel_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0]  ctrl_reg, opc_reg, gap_reg, page_reg;
    logic [15:0] hold_reg;
    logic [8:0]  map_reg;
    logic [31:0] prdata_reg;
    sfr_eng_type eng_st, st_next;
    logic        own_vld_reg, buf_full_reg, busy_reg;

    wire        apb_wr    = psel_i & penable_i & pwrite_i;
    wire        apb_setup = psel_i & ~penable_i;
    wire        sel_ctrl  = paddr_i == `SFR_OFS_CTRL;
    wire        sel_opc   = paddr_i == `SFR_OFS_OPC;
    wire        sel_gap   = paddr_i == `SFR_OFS_GAP;
    wire        sel_hold  = paddr_i == `SFR_OFS_HOLD;
    wire        sel_page  = paddr_i == `SFR_OFS_PAGE;
    wire        sel_map   = paddr_i == `SFR_OFS_MAP;
    wire        mapped    = sel_ctrl | sel_opc | sel_gap | sel_hold | sel_page | sel_map;
    wire        mbe       = ctrl_reg[`SFR_B_MBE];
    wire [1:0]  div       = ctrl_reg[`SFR_B_DIV +: 2];
    wire        pad       = ctrl_reg[`SFR_B_PAD];
    wire        dual      = ctrl_reg[`SFR_B_DUAL];
    wire        css       = ctrl_reg[`SFR_B_CSS];
    wire        pks       = ctrl_reg[`SFR_B_PKS];
    // Pins stay ours until bridge enable is clear and the engine and the owner are both done
    wire        active    = mbe | own_vld_reg | (eng_st != ST_IDLE);
    wire [31:0] rd_mux    = sel_ctrl ? {24'h0, ctrl_reg[7:2], active, mbe} :
                            sel_opc  ? {24'h0, opc_reg} :
                            sel_gap  ? {24'h0, gap_reg} :
                            sel_hold ? {16'h0, hold_reg} :
                            sel_page ? {24'h0, page_reg} :
                            sel_map  ? {23'h0, map_reg} : 32'h0;

    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~mapped;
    assign prdata_o  = prdata_reg;
    assign pin_sel_o = active;

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl_reg <= `SFR_RST_CTRL;
            opc_reg  <= `SFR_RST_OPC;
            gap_reg  <= `SFR_RST_GAP;
            hold_reg <= `SFR_RST_HOLD;
            page_reg <= `SFR_RST_PAGE;
            map_reg  <= `SFR_RST_MAP;
        end else if (apb_wr) begin
            if (sel_ctrl) ctrl_reg <= pwdata_i[7:0] & `SFR_CTRL_WMASK;
            if (sel_opc)  opc_reg  <= pwdata_i[7:0];
            if (sel_gap)  gap_reg  <= pwdata_i[7:0];
            if (sel_hold) hold_reg <= pwdata_i[15:0];
            if (sel_page) page_reg <= pwdata_i[7:0];
            if (sel_map)  map_reg  <= pwdata_i[8:0];
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) prdata_reg <= 32'h0;
        else if (apb_setup) prdata_reg <= rd_mux;
    end

    ////////////////////////////////////////////////////////////////////////////
    // AHB side: owner, pending masters, split answers
    sfr_resp_type resp_st;
    logic [3:0]  own_id_reg;
    logic [2:0]  words_left_reg;
    logic [23:0] fl_addr_reg, cont_reg;
    logic [31:0] buf_reg, hrdata_reg;
    logic [15:0] pend_reg, split_reg;
    logic [1:0]  launch_reg;
    logic        word_done;
    logic [31:0] buf_in;

    wire        ap_take  = hsel_i & htrans_i[1] & hready_i;
    wire        rd_req   = ap_take & (haddr_i[31:22] == `SFR_WIN_TAG) & ~hwrite_i
                           & (mbe | own_vld_reg);
    wire        is_own   = own_vld_reg & (hmaster_i == own_id_reg);
    wire        new_own  = rd_req & ~own_vld_reg;
    wire        deliver  = rd_req & is_own & buf_full_reg;
    wire        do_split = rd_req & ~deliver;
    wire        pend_set = rd_req & own_vld_reg & ~is_own;
    wire        last_wd  = deliver & (words_left_reg == 3'h1);
    // Only 16 bytes of burst length are kept
    wire [2:0]  words_in = (hburst_i >= 3'b010) ? 3'h4 : 3'h1;
    wire [4:0]  low_cnt  = map_reg[4:0];
    wire [23:0] low_mask = ~(24'hffffff << low_cnt);
    wire [23:0] paged_a  = ({16'h0, page_reg} << low_cnt) | (haddr_i[23:0] & low_mask);
    wire [23:0] raw_a    = {2'b00, haddr_i[21:0]};
    wire [23:0] fl_in    = (map_reg[`SFR_B_PAGED] ? paged_a : raw_a) & 24'hfffffc;
    wire [1:0]  div_m1   = (div == 2'b01) ? 2'h1 : (div == 2'b10) ? 2'h0 : 2'h3;
    wire        fetch_go = own_vld_reg & ~buf_full_reg & ~busy_reg & (launch_reg == 2'h0);
    wire        seq      = fl_addr_reg == cont_reg;
    wire        start    = fetch_go & ((eng_st == ST_IDLE) | ((eng_st == ST_HOLD) & seq));

    assign hready_o = resp_st != RS_SPL1;
    assign hresp_o  = (resp_st == RS_IDLE) ? `SFR_HRESP_OK : `SFR_HRESP_SPLIT;
    assign hrdata_o = hrdata_reg;
    assign hsplit_o = split_reg;

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            resp_st    <= RS_IDLE;
            hrdata_reg <= 32'h0;
            split_reg  <= 16'h0;
            pend_reg   <= 16'h0;
        end else begin
            resp_st   <= (resp_st == RS_SPL1) ? RS_SPL2 : (do_split ? RS_SPL1 : RS_IDLE);
            split_reg <= (word_done ? (16'h1 << own_id_reg) : 16'h0)
                         | (last_wd ? pend_reg : 16'h0);
            // A new waiter in the release cycle stays pending
            pend_reg  <= (last_wd ? 16'h0 : pend_reg) | (pend_set ? (16'h1 << hmaster_i) : 16'h0);
            if (ap_take) hrdata_reg <= deliver ? buf_reg : 32'h0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            own_vld_reg    <= 1'b0;
            own_id_reg     <= 4'h0;
            words_left_reg <= 3'h0;
            fl_addr_reg    <= 24'h0;
            cont_reg       <= 24'hffffff;
            buf_reg        <= 32'h0;
            buf_full_reg   <= 1'b0;
            busy_reg       <= 1'b0;
            launch_reg     <= 2'h0;
        end else begin
            if (new_own) begin
                own_vld_reg    <= 1'b1;
                own_id_reg     <= hmaster_i;
                words_left_reg <= words_in;
                fl_addr_reg    <= fl_in;
            end else if (last_wd) begin
                own_vld_reg <= 1'b0;
            end else if (deliver) begin
                words_left_reg <= words_left_reg - 3'h1;
            end
            if (word_done) begin
                buf_reg     <= buf_in;
                fl_addr_reg <= fl_addr_reg + 24'h4;
                cont_reg    <= fl_addr_reg + 24'h4;
            end
            buf_full_reg <= word_done | (buf_full_reg & ~deliver);
            busy_reg     <= start | (busy_reg & ~word_done);
            if (deliver & ~last_wd) launch_reg <= pks ? 2'h0 : div_m1;
            else if (launch_reg != 2'h0) launch_reg <= launch_reg - 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial engine
    logic [16:0] cnt_reg;
    logic [6:0]  clk_left_reg;
    logic [39:0] tx_reg;
    logic        cs_n_reg, sck_reg, div_ph_reg;

    wire        in_shift   = eng_st == ST_SHIFT;
    wire        fast       = div == 2'b10;
    wire        tick       = (div == 2'b01) | div_ph_reg;
    wire        shift_rise = in_shift & (fast | (tick & ~sck_reg));
    wire        shift_fall = in_shift & (fast | (tick & sck_reg));
    wire        shift_end  = shift_fall & (clk_left_reg == 7'h01);
    wire [6:0]  data_clks  = dual ? `SFR_DUAL_CLKS : `SFR_WORD_CLKS;
    wire [6:0]  total_clks = `SFR_HDR_CLKS + (pad ? `SFR_PAD_CLKS : 7'h0) + data_clks;
    wire        data_clk   = clk_left_reg <= data_clks;
    wire [16:0] cnt_inc    = cnt_reg + 17'h1;
    wire        lead_done  = cnt_inc >= (css ? `SFR_LEAD_SHORT : `SFR_LEAD_CYC);
    wire        hold_done  = cnt_inc >= ({1'b0, hold_reg} + `SFR_HOLD_EXTRA);
    wire        gap_done   = cnt_inc >= ({9'h0, gap_reg} + `SFR_GAP_EXTRA);
    wire        hold_zero  = hold_reg == 16'h0;
    wire        cs_on_next = (st_next == ST_LEAD) | (st_next == ST_SHIFT) | (st_next == ST_HOLD);
    wire [16:0] cnt_next   = (st_next != eng_st) ? 17'h0 : cnt_inc;
    wire        sck_next   = in_shift & ~fast & (sck_reg ^ tick);
    wire [39:0] tx_next    = (start & (eng_st == ST_IDLE)) ? {opc_reg, fl_addr_reg, 8'h00} :
                             shift_fall ? {tx_reg[38:0], 1'b0} : tx_reg;
    wire [6:0]  left_next  = (start & (eng_st == ST_IDLE)) ? total_clks :
                             start ? data_clks :
                             shift_fall ? clk_left_reg - 7'h1 : clk_left_reg;

    always_comb begin
        st_next = eng_st;
        unique case (eng_st)
            ST_IDLE:  if (start) st_next = ST_LEAD;
            ST_LEAD:  if (lead_done) st_next = ST_SHIFT;
            ST_SHIFT: if (shift_end) st_next = hold_zero ? ST_GAP : ST_HOLD;
            ST_HOLD: begin
                if (fetch_go) st_next = seq ? ST_SHIFT : ST_GAP;
                else if (hold_done) st_next = ST_GAP;
            end
            ST_GAP:   if (gap_done) st_next = ST_IDLE;
            default:  st_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            eng_st       <= ST_IDLE;
            cnt_reg      <= 17'h0;
            cs_n_reg     <= 1'b1;
            sck_reg      <= 1'b0;
            div_ph_reg   <= 1'b0;
            clk_left_reg <= 7'h0;
            tx_reg       <= 40'h0;
        end else begin
            eng_st       <= st_next;
            cnt_reg      <= cnt_next;
            cs_n_reg     <= ~cs_on_next;
            sck_reg      <= sck_next;
            div_ph_reg   <= in_shift & ~div_ph_reg;
            clk_left_reg <= left_next;
            tx_reg       <= tx_next;
        end
    end

    // Undivided mode gates the inverted clock; a glitch-free gate cell is assumed
    assign sck_o    = fast ? (in_shift & ~sys_clk_i) : sck_reg;
    assign cs_n_o   = cs_n_reg;
    assign io0_o    = tx_reg[39];
    assign io0_oe_o = (eng_st == ST_LEAD) | (in_shift & ~data_clk);

    ////////////////////////////////////////////////////////////////////////////
    // Receive path: pins synchronised, sample strobe delayed to match
    logic       io0_s1, io0_s2, io1_s1, io1_s2;
    logic [1:0] samp_pipe;
    logic [31:0] rx_reg;
    logic [5:0] rx_cnt_reg;

    wire [5:0]  rx_step = dual ? 6'h02 : 6'h01;
    wire [31:0] rx_new  = dual ? {rx_reg[29:0], io1_s2, io0_s2} : {rx_reg[30:0], io1_s2};
    assign word_done = samp_pipe[1] & ((rx_cnt_reg + rx_step) == `SFR_WORD_BITS);
    // First flash byte lands in the lowest AHB byte lane
    assign buf_in    = {rx_new[7:0], rx_new[15:8], rx_new[23:16], rx_new[31:24]};

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            {io0_s1, io0_s2, io1_s1, io1_s2} <= 4'h0;
            samp_pipe  <= 2'h0;
            rx_reg     <= 32'h0;
            rx_cnt_reg <= 6'h0;
        end else begin
            {io0_s1, io0_s2, io1_s1, io1_s2} <= {io0_i, io0_s1, io1_i, io1_s1};
            samp_pipe <= {samp_pipe[0], shift_rise & data_clk};
            if (samp_pipe[1]) begin
                rx_reg     <= rx_new;
                rx_cnt_reg <= word_done ? 6'h0 : rx_cnt_reg + rx_step;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);

    logic [8:0] hi_cnt_reg;
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) hi_cnt_reg <= 9'h1ff;
        else hi_cnt_reg <= !cs_n_o ? 9'h0 : (hi_cnt_reg == 9'h1ff ? hi_cnt_reg : hi_cnt_reg + 9'h1);
    end

    sequence split_two;
        !hready_o && hresp_o == `SFR_HRESP_SPLIT ##1 hready_o && hresp_o == `SFR_HRESP_SPLIT;
    endsequence

    split_first_a: assert property (new_own |=> split_two)
        else $error("first read not split");
    regrant_own_a: assert property (word_done |=> hsplit_o[own_id_reg])
        else $error("owner not re-granted");
    regrant_pend_a: assert property (last_wd |=> (hsplit_o & $past(pend_reg)) == $past(pend_reg))
        else $error("pending masters not re-granted");
    mux_take_a: assert property (apb_wr && sel_ctrl && pwdata_i[0] |=> pin_sel_o)
        else $error("mux not taken");
    lead_time_a: assert property ($fell(cs_n_o) && !css |-> eng_st == ST_LEAD ##1
        eng_st == ST_LEAD ##1 eng_st == ST_SHIFT) else $error("lead time wrong");
    gap_min_a: assert property ($fell(cs_n_o) |-> hi_cnt_reg > {1'b0, gap_reg})
        else $error("select gap too short");
    hold_zero_a: assert property (shift_end && hold_zero |=> cs_n_o)
        else $error("select not released");
    seq_skip_a: assert property (eng_st == ST_HOLD && start |=>
        in_shift && !cs_n_o && clk_left_reg == $past(data_clks)) else $error("sequential skip");
    cmd_io0_a: assert property ($rose(io0_oe_o) |-> $fell(cs_n_o) && eng_st == ST_LEAD)
        else $error("io0 driven outside a frame start");
    mode0_a: assert property (in_shift && !fast && $changed(io0_o) |-> !sck_reg)
        else $error("io0 changed with clock high");
    div4_a: assert property (in_shift && div == 2'b00 && $rose(sck_reg) |->
        ##1 sck_reg ##1 !sck_reg) else $error("divide by four wrong");

endmodule : sfr_bridge

// *** sfr_flash_model.sv ***
module sfr_flash_model (
    // Link side
    input  wire logic        clk_i,
    input  wire logic        sck_i,
    input  wire logic        cs_n_i,
    input  wire logic        io0_i,
    output logic             io0_o,
    output logic             io0_oe_o,
    output logic             io1_o,
    // Observed command
    output int               frames_o,
    output logic      [7:0]  opc_o,
    output logic      [23:0] addr_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int          cnt = 0;
    int          k;
    int          j;
    logic [31:0] hdr;
    logic [7:0]  by;
    logic        drv = 0, dual = 0, d, b0 = 0, b1 = 0, tog = 0;
    initial frames_o = 0;
    function automatic logic [7:0] mb(input logic [23:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction : mb
    ////////////////////////////////////////
    always @(negedge cs_n_i) begin
        cnt = 0;
        frames_o++;
    end
    always @(posedge sck_i) if (!cs_n_i) begin
        hdr = {hdr[30:0], io0_i};
        cnt++;
        if (cnt == 32) begin
            opc_o  = hdr[31:24];
            addr_o = hdr[23:0];
        end
    end
    // Sequential data continues while select stays low
    always @(negedge sck_i) if (!cs_n_i && cnt >= 32) begin
        k = cnt - 32 - ((opc_o == 8'h03) ? 0 : 8);
        if (k >= 0) begin
            d  = (opc_o == 8'h3b);
            by = mb(addr_o + 24'(d ? k / 4 : k / 8));
            j  = d ? 7 - 2 * (k % 4) : 7 - k % 8;
            b1   <= by[j];
            b0   <= d ? by[j - 1] : 1'b0;
            drv  <= 1'b1;
            dual <= d;
        end
    end
    always @(posedge cs_n_i) drv <= 1'b0;
    // Released line toggles so a stale value never reads as data
    always @(posedge clk_i) tog <= ~tog;
    assign io1_o    = drv ? b1 : tog;
    assign io0_o    = b0;
    assign io0_oe_o = drv & dual;
endmodule : sfr_flash_model

// *** test_ahb_serial_flash_read_bridge.sv ***
`include "sfr_regs.svh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
    $display("ERROR %s expected %h seen %h", n, e, g); end end
module test_ahb_serial_flash_read_bridge;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, nrst = 0, psel = 0, pen = 0, pwr = 0, hsel = 0, io0q = 0;
    logic [7:0]  pa = 0, pg = 0, fopc;
    logic [31:0] pwd = 0, ha = 0, q, d, a;
    logic [23:0] faddr;
    logic [1:0]  ht = 0, r;
    logic [2:0]  hb = 0;
    logic [3:0]  hm = 0;
    logic        e, pg_on = 0, hw = 0;
    wire  [31:0] prd, hrd;
    wire  [1:0]  hresp;
    wire  [15:0] hspl;
    wire         prdy, perr, hrdy, sck, csn, io0o, io0e, pins, fio0, fio0e, fio1;
    wire         io0 = io0e ? io0o : fio0e ? fio0 : ~io0q;
    int miscompares = 0, samples_checked = 0, seed = 32'h4280, lc = 21;
    int sc[16], seen[16], frames, f0, gmin = 999, grun = 0;
    sfr_bridge i_sfr_bridge (.sys_clk_i(clk), .nrst_i(nrst), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd),
        .pready_o(prdy), .pslverr_o(perr), .hsel_i(hsel), .htrans_i(ht), .hwrite_i(hw),
        .haddr_i(ha), .hburst_i(hb), .hmaster_i(hm), .hready_i(hrdy), .hrdata_o(hrd),
        .hready_o(hrdy), .hresp_o(hresp), .hsplit_o(hspl), .sck_o(sck), .cs_n_o(csn),
        .io0_o(io0o), .io0_oe_o(io0e), .io0_i(io0), .io1_i(fio1), .pin_sel_o(pins));
    sfr_flash_model i_sfr_flash_model (.clk_i(clk), .sck_i(sck), .cs_n_i(csn), .io0_i(io0),
        .io0_o(fio0), .io0_oe_o(fio0e), .io1_o(fio1), .frames_o(frames), .opc_o(fopc),
        .addr_o(faddr));
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        io0q <= io0;
        for (int i = 0; i < 16; i++) if (hspl[i] === 1'b1) sc[i]++;
        if (csn === 1'b1) grun++;
        else begin
            if (grun > 0 && grun < gmin) gmin = grun;
            grun = 0;
        end
    end
    ////////////////////////////////////////
    function automatic logic [23:0] fa(input logic [31:0] h);
        // Raw address keeps only the 22 lines that a 4 MB part decodes
        return pg_on ? (24'(pg) << lc) | (h[23:0] & ((24'h1 << lc) - 1)) : {2'b00, h[21:0]};
    endfunction : fa
    function automatic logic [7:0] mb(input logic [23:0] x);
        return x[7:0] ^ x[15:8] ^ 8'h5a;
    endfunction : mb
    function automatic logic [31:0] ew(input logic [31:0] h);
        return {mb(fa(h) + 3), mb(fa(h) + 2), mb(fa(h) + 1), mb(fa(h))};
    endfunction : ew
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
        psel <= 1;
        pwr  <= w;
        pa   <= ad;
        pwd  <= wd;
        @(posedge clk);
        pen <= 1;
        @(posedge clk);
        for (int k = 0; k < 100 && prdy !== 1'b1; k++) @(posedge clk);
        if (prdy !== 1'b1) miscompares++;
        q = prd;
        e = perr;
        psel <= 0;
        pen  <= 0;
        @(posedge clk);
    endtask : apb
    task automatic ahb_try(input int id, input logic [31:0] ad);
        hsel <= 1;
        ht   <= 2'b10;
        ha   <= ad;
        hm   <= 4'(id);
        @(posedge clk);
        hsel <= 0;
        ht   <= 2'b00;
        @(posedge clk);
        r = hresp;
        d = hrd;
        if (r === `SFR_HRESP_SPLIT) @(posedge clk);
    endtask : ahb_try
    task automatic wsp(input int id);
        int k;
        k = 0;
        while (k < 5000 && sc[id] == seen[id]) begin
            @(posedge clk);
            #1;
            k++;
        end
        seen[id] = sc[id];
        @(posedge clk);
        `CHK("hsplit", 1'b1, k < 5000)
    endtask : wsp
    // Retry after each re-grant, at most four times, until a word arrives
    task automatic fin(input int id, input logic [31:0] ad);
        for (int n = 0; n < 4; n++) begin
            wsp(id);
            ahb_try(id, ad);
            if (r === `SFR_HRESP_OK) break;
        end
        `CHK("hrdata", ew(ad), d)
    endtask : fin
    task automatic rd(input int id, input logic [31:0] ad);
        ahb_try(id, ad);
        `CHK("split", `SFR_HRESP_SPLIT, r)
        fin(id, ad);
    endtask : rd
    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : finish_test
    ////////////////////////////////////////
    initial begin
        logic [7:0]  ofs[6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
        logic [31:0] rv[6]  = '{32'h03, 32'h03, 32'h07, 32'h10, 32'h00, 32'h15};
        logic [7:0]  opt[3] = '{8'h03, 8'h0b, 8'h3b};
        repeat (8) @(posedge clk);
        nrst <= 1;
        @(posedge clk);
        for (int i = 0; i < 6; i++) begin
            apb(0, ofs[i], 0);
            `CHK("reg", rv[i], q)
        end
        apb(0, 8'h18, 0);
        `CHK("pslverr", 1'b1, e)
        // Hand the pins back while idle, then grab them again
        apb(1, `SFR_OFS_CTRL, 0);
        repeat (2) @(posedge clk);
        `CHK("pin_sel", 1'b0, pins)
        apb(0, `SFR_OFS_CTRL, 0);
        `CHK("ctrl", 32'h0, q)
        ahb_try(1, 32'h0040_0000);
        `CHK("hresp", `SFR_HRESP_OK, r)
        apb(1, `SFR_OFS_CTRL, 1);
        `CHK("pin_sel", 1'b1, pins)
        hw <= 1;
        ahb_try(3, 32'h0040_0000);
        hw <= 0;
        `CHK("hresp", `SFR_HRESP_OK, r)
        `CHK("hrdata", 32'h0, d)
        apb(1, `SFR_OFS_GAP, 3);
        apb(1, `SFR_OFS_HOLD, 0);
        for (int i = 0; i < 3; i++) begin
            apb(1, `SFR_OFS_OPC, opt[i]);
            apb(1, `SFR_OFS_CTRL, 1 | i << 2 | (i > 0) << 4 | (i == 2) << 5 | (i == 1) << 6
                | (i == 2) << 7);
            f0 = frames;
            a  = 32'h0040_0000 | ($random(seed) & 32'h003f_fffc);
            rd(1, a);
            `CHK("opcode", opt[i], fopc)
            `CHK("faddr", fa(a), faddr)
            `CHK("frames", f0 + 1, frames)
        end
        apb(1, `SFR_OFS_CTRL, 32'h05);
        apb(1, `SFR_OFS_OPC, 32'h03);
        apb(1, `SFR_OFS_HOLD, 32'h0100);
        a = 32'h0040_0000 | ($random(seed) & 32'h003f_ff00);
        rd(1, a);
        f0 = frames;
        rd(1, a + 4);
        `CHK("frames", f0, frames)
        rd(1, a + 32'h40);
        `CHK("frames", f0 + 1, frames)
        apb(1, `SFR_OFS_HOLD, 0);
        ahb_try(1, a);
        ahb_try(2, a + 32'h80);
        `CHK("split", `SFR_HRESP_SPLIT, r)
        fin(1, a);
        fin(2, a + 32'h80);
        apb(1, `SFR_OFS_MAP, 32'h114);
        apb(1, `SFR_OFS_PAGE, 32'h03);
        pg_on = 1;
        pg    = 8'h03;
        lc    = 20;
        hb <= 3'b011;
        a = 32'h0040_0000 | ($random(seed) & 32'h003f_fff0);
        for (int i = 0; i < 4; i++) rd(1, a + 4 * i);
        hb <= 3'b000;
        `CHK("faddr", fa(a + 12), faddr)
        `CHK("gap", 1'b1, gmin >= 4)
        finish_test;
    end
    initial begin
        #900000;
        miscompares++;
        finish_test;
    end
endmodule : test_ahb_serial_flash_read_bridge
